// ===== logic/mtc_pkg.sv
// Constants, field layout and types of the five-channel timer core
package mtc_pkg;
  localparam int NCH = 5;
  localparam int NGR = 16;
  localparam int CW  = 16;
  // Register indices on the plain port
  localparam logic [5:0] A_CNT   = 6'h00;
  localparam logic [5:0] A_GR    = 6'h08;
  localparam logic [5:0] A_GR_E  = 6'h17;
  localparam logic [5:0] A_RUN   = 6'h18;
  localparam logic [5:0] A_SYNC  = 6'h19;
  localparam logic [5:0] A_CTL   = 6'h20;
  localparam logic [5:0] A_STAT  = 6'h28;
  // Reset values
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] GR_RST  = 16'hFFFF;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] CTL_RST = 16'h0000;
  localparam logic [7:0]  RUN_RST = 8'h00;
  localparam logic [7:0]  SYN_RST = 8'h00;
  localparam logic [7:0]  RSV_MSK = 8'hC7;
  // Run and select bit positions of channels three and four
  localparam int CH3_BIT = 6;
  localparam int CH4_BIT = 7;
  // Channel control fields
  localparam int CF_MODE = 0;
  localparam int CF_CLR  = 3;
  localparam int CF_CAP  = 5;
  localparam int CF_INIT = 6;
  localparam int CF_BUF  = 7;
  // Status fields
  localparam int ST_UNF  = 5;
  localparam int ST_DIR  = 8;
  // General register placement per channel
  localparam logic [3:0] GR_BASE [NCH] = '{4'h0, 4'h4, 4'h6, 4'h8, 4'hC};
  localparam logic [3:0] GR_THIRD = 4'h2;
  localparam logic [3:0] GR_FOURTH = 4'h3;
  // Count clock prescale
  localparam logic [1:0] PRE_LAST = 2'h3;
  typedef enum logic [2:0] {
    MTC_NORMAL, MTC_PHASE, MTC_CASCADE, MTC_CPWM, MTC_RPWM
  } mtc_mode_t;
  typedef enum logic [1:0] {
    MTC_CLR_NONE, MTC_CLR_OWN, MTC_CLR_SYNC
  } mtc_clr_t;
endpackage

// ===== logic/mtc_core.sv
// Five-channel 16-bit timer counting core with register port
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - Five independent 16-bit counters, channels zero to four.
// - Counters clear on power-on reset and standby; there is no manual reset.
// - Channels one, two count down only in phase or cascade mode.
// - Channels three, four count down only in complementary PWM; zero up.
// - Each general register is 16 bits, compare or capture.
// - Sixteen general registers: four on 0,3,4 and two on 1,2.
// - On 0,3,4 third buffers first, fourth buffers second.
// - General registers set to all ones on reset and standby.
// - Run bits: 7 channel four, 6 channel three, 2..0 channels two..zero.
// - Run register clears on reset and standby, halting all counters.
// - Clearing run during compare output stops counter; pin level kept outside PWM modes.
// - Control write while halted drives pin to configured initial level.
// - PWM modes: clearing run returns output pin to initial level.
// - Bits 5..3 of run and select registers read zero.
// - Select bits use the same layout; one means synchronous operation.
// - Synchronous channels preset together and clear with each other.
// - Select register clears on reset and standby, all independent.
// - Direction status for channels one to four: one up, zero down.
// - Overflow flag on max to zero; underflow on channels one, two.
module mtc_core
  import mtc_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             standby,
  input  wire logic [5:0]       addr,
  input  wire logic [15:0]      wr_data,
  input  wire logic             wr_en,
  input  wire logic             rd_en,
  output var  logic [15:0]      rd_data_r,
  input  wire logic [NCH-1:0]   phase_up,
  input  wire logic [NCH-1:0]   phase_dn,
  input  wire logic [NCH-1:0]   pin_in,
  output var  logic [NCH-1:0]   pin_out_r,
  output var  logic [NCH-1:0]   pin_oe_r
);

  // ****************************************
  // State
  // ****************************************
  logic [15:0]    cnt_r [NCH];
  logic [15:0]    cnt_nxt [NCH];
  logic [15:0]    gr_r [NGR];
  logic [15:0]    gr_nxt [NGR];
  logic [15:0]    ctl_r [NCH];
  logic [7:0]     run_r;
  logic [7:0]     sync_r;
  logic [NCH-1:0] ovf_r;
  logic [NCH-1:0] dn_r;
  logic [2:1]     unf_r;
  logic [1:0]     pre_r;
  logic [NCH-1:0] wup_r;
  logic [NCH-1:0] wdn_r;
  logic [NCH-1:0] pin_nxt;

  // ****************************************
  // Decode
  // ****************************************
  wire            rst_all = sys_rst | standby;
  wire            tick    = (pre_r == PRE_LAST);
  wire [NCH-1:0]  run5    = {run_r[CH4_BIT], run_r[CH3_BIT], run_r[2:0]};
  wire [NCH-1:0]  sync5   = {sync_r[CH4_BIT], sync_r[CH3_BIT], sync_r[2:0]};
  wire [7:0]      run_w   = wr_data[7:0] & RSV_MSK;
  wire [NCH-1:0]  run5_w  = {run_w[CH4_BIT], run_w[CH3_BIT], run_w[2:0]};
  wire            wr_run  = wr_en && (addr == A_RUN);
  wire            wr_sync = wr_en && (addr == A_SYNC);
  wire            wr_stat = wr_en && (addr == A_STAT);
  wire            wr_gr   = wr_en && (addr >= A_GR) && (addr <= A_GR_E);
  wire [3:0]      gr_idx  = 4'(addr - A_GR);
  wire [NCH-1:0]  wr_cnt_c;
  wire [NCH-1:0]  wr_ctl_c;
  wire [NCH-1:0]  run_off = wr_run ? (run5 & ~run5_w) : '0;

  for (genvar c = 0; c < NCH; c++) begin : g_dec
    assign wr_cnt_c[c] = wr_en && (addr == A_CNT + 6'(c));
    assign wr_ctl_c[c] = wr_en && (addr == A_CTL + 6'(c));
  end

  // Preset reaches every selected channel when one of them is written
  wire            sync_ld = |(wr_cnt_c & sync5);

  // ****************************************
  // Per-channel counting
  // ****************************************
  mtc_mode_t      mode [NCH];
  mtc_clr_t       csrc [NCH];
  logic [NCH-1:0] up_ev;
  logic [NCH-1:0] dn_ev;
  logic [NCH-1:0] ud_ok;
  logic [NCH-1:0] ld;
  logic [NCH-1:0] match;
  logic [NCH-1:0] cap_ev;
  logic [NCH-1:0] clr_own;
  logic [NCH-1:0] clr;
  logic [NCH-1:0] ovf_ev;
  logic [NCH-1:0] unf_ev;
  logic [NCH-1:0] dir_nxt;

  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      mode[c] = mtc_mode_t'(ctl_r[c][CF_MODE +: 3]);
      csrc[c] = mtc_clr_t'(ctl_r[c][CF_CLR +: 2]);
      dir_nxt[c] = dn_r[c];
      up_ev[c] = 1'b0;
      dn_ev[c] = 1'b0;
      ud_ok[c] = 1'b0;
      if (c == 1 || c == 2) begin
        ud_ok[c] = (mode[c] == MTC_PHASE) || (mode[c] == MTC_CASCADE);
      end else if (c >= 3) begin
        ud_ok[c] = (mode[c] == MTC_CPWM);
      end
      match[c] = (cnt_r[c] == gr_r[GR_BASE[c]]);
      if (ud_ok[c] && mode[c] == MTC_PHASE) begin
        up_ev[c] = phase_up[c] & ~phase_dn[c];
        dn_ev[c] = phase_dn[c] & ~phase_up[c];
      end else if (ud_ok[c] && mode[c] == MTC_CASCADE) begin
        // Registered wraps of the neighbour, so no loop between channels
        up_ev[c] = (c == 1) ? wup_r[2] : wup_r[0];
        dn_ev[c] = (c == 1) ? wdn_r[2] : 1'b0;
      end else if (ud_ok[c]) begin
        // Triangle between zero and the first general register
        if (tick) begin
          if (!dn_r[c] && match[c]) begin
            dir_nxt[c] = 1'b1;
          end else if (dn_r[c] && cnt_r[c] == CNT_RST) begin
            dir_nxt[c] = 1'b0;
          end
          up_ev[c] = !dir_nxt[c];
          dn_ev[c] = dir_nxt[c];
        end
      end else begin
        up_ev[c] = tick;
        dir_nxt[c] = 1'b0;
      end
      up_ev[c] = up_ev[c] & run5[c];
      dn_ev[c] = dn_ev[c] & run5[c] & ud_ok[c];
      if (up_ev[c] && !dn_ev[c]) begin
        dir_nxt[c] = 1'b0;
      end else if (dn_ev[c]) begin
        dir_nxt[c] = 1'b1;
      end
      cap_ev[c] = run5[c] & ctl_r[c][CF_CAP] & pin_in[c];
      clr_own[c] = (csrc[c] == MTC_CLR_OWN) &&
                   (ctl_r[c][CF_CAP] ? cap_ev[c] : (match[c] & up_ev[c]));
      ld[c] = wr_cnt_c[c] | (sync_ld & sync5[c]);
    end
    for (int c = 0; c < NCH; c++) begin
      // Follows any other selected channel that clears itself
      clr[c] = clr_own[c] | ((csrc[c] == MTC_CLR_SYNC) && sync5[c] &&
               run5[c] && |(clr_own & sync5));
      ovf_ev[c] = up_ev[c] && (cnt_r[c] == CNT_MAX) && !ld[c] && !clr[c];
      unf_ev[c] = dn_ev[c] && (cnt_r[c] == CNT_RST) && !ld[c] && !clr[c];
      if (ld[c]) begin
        cnt_nxt[c] = wr_data;
      end else if (clr[c]) begin
        cnt_nxt[c] = CNT_RST;
      end else if (dn_ev[c]) begin
        cnt_nxt[c] = cnt_r[c] - 16'h0001;
      end else if (up_ev[c]) begin
        cnt_nxt[c] = cnt_r[c] + 16'h0001;
      end else begin
        cnt_nxt[c] = cnt_r[c];
      end
    end
  end

  // ****************************************
  // General registers, capture and buffers
  // ****************************************
  always_comb begin
    for (int g = 0; g < NGR; g++) begin
      gr_nxt[g] = gr_r[g];
    end
    for (int c = 0; c < NCH; c++) begin
      if (cap_ev[c]) begin
        gr_nxt[GR_BASE[c]] = cnt_r[c];
        if (c != 1 && c != 2 && ctl_r[c][CF_BUF]) begin
          gr_nxt[GR_BASE[c] + GR_THIRD] = gr_r[GR_BASE[c]];
        end
      end else if (!ctl_r[c][CF_CAP] && match[c] && run5[c] &&
                   c != 1 && c != 2 && ctl_r[c][CF_BUF]) begin
        // Buffered compare: reload first and second from third and fourth
        gr_nxt[GR_BASE[c]] = gr_r[GR_BASE[c] + GR_THIRD];
        gr_nxt[GR_BASE[c] + 4'h1] = gr_r[GR_BASE[c] + GR_FOURTH];
      end
    end
    if (wr_gr) begin
      gr_nxt[gr_idx] = wr_data;
    end
  end

  // ****************************************
  // Pin output level
  // ****************************************
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      pin_nxt[c] = pin_out_r[c];
      if (wr_ctl_c[c] && !run5[c]) begin
        pin_nxt[c] = wr_data[CF_INIT];
      end else if (run_off[c] && !ctl_r[c][CF_CAP] &&
                   (mode[c] == MTC_CPWM || mode[c] == MTC_RPWM)) begin
        pin_nxt[c] = ctl_r[c][CF_INIT];
      end else if (!ctl_r[c][CF_CAP] && match[c] && (up_ev[c] | dn_ev[c])) begin
        pin_nxt[c] = ~pin_out_r[c];
      end
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  // Standby clears all but the read data; there is no manual reset input by design
  always_ff @(posedge clk) begin
    if (rst_all) begin
      for (int c = 0; c < NCH; c++) begin
        cnt_r[c] <= CNT_RST;
        ctl_r[c] <= CTL_RST;
      end
      for (int g = 0; g < NGR; g++) begin
        gr_r[g] <= GR_RST;
      end
      run_r  <= RUN_RST;
      sync_r <= SYN_RST;
      pre_r  <= '0;
      pin_out_r <= '0;
      pin_oe_r  <= '0;
    end else begin
      cnt_r <= cnt_nxt;
      gr_r  <= gr_nxt;
      pre_r <= tick ? '0 : pre_r + 2'h1;
      pin_out_r <= pin_nxt;
      for (int c = 0; c < NCH; c++) begin
        if (wr_ctl_c[c]) begin
          ctl_r[c] <= wr_data;
        end
        pin_oe_r[c] <= !ctl_r[c][CF_CAP];
      end
      if (wr_run) begin
        run_r <= run_w;
      end
      if (wr_sync) begin
        sync_r <= wr_data[7:0] & RSV_MSK;
      end
    end
  end

  // Flags: a wrap in the clearing cycle wins over the zero write
  always_ff @(posedge clk) begin
    if (rst_all) begin
      ovf_r <= '0;
      unf_r <= '0;
      dn_r  <= '0;
      wup_r <= '0;
      wdn_r <= '0;
    end else begin
      ovf_r <= ovf_ev | (ovf_r & ~(wr_stat ? ~wr_data[4:0] : 5'h00));
      unf_r <= unf_ev[2:1] |
               (unf_r & ~(wr_stat ? ~wr_data[ST_UNF +: 2] : 2'h0));
      dn_r  <= dir_nxt;
      wup_r <= ovf_ev;
      wdn_r <= unf_ev;
    end
  end

  // ****************************************
  // Read port
  // ****************************************
  wire [15:0] stat_w = {4'h0, ~dn_r[4:1], 1'b0, unf_r, ovf_r};
  logic [15:0] rd_sel;

  always_comb begin
    rd_sel = 16'h0000;
    for (int c = 0; c < NCH; c++) begin
      if (addr == A_CNT + 6'(c)) begin
        rd_sel = cnt_r[c];
      end
      if (addr == A_CTL + 6'(c)) begin
        rd_sel = ctl_r[c];
      end
    end
    if (addr >= A_GR && addr <= A_GR_E) begin
      rd_sel = gr_r[gr_idx];
    end
    if (addr == A_RUN) begin
      rd_sel = {8'h00, run_r};
    end
    if (addr == A_SYNC) begin
      rd_sel = {8'h00, sync_r};
    end
    if (addr == A_STAT) begin
      rd_sel = stat_w;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_data_r <= 16'h0000;
    end else begin
      rd_data_r <= rd_en ? rd_sel : 16'h0000;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  AST_CH0_UP: assert property (!dn_ev[0])
    else $error("channel zero counted down");
  AST_CH1_DIR: assert property (dn_ev[1] |->
    (mode[1] == MTC_PHASE || mode[1] == MTC_CASCADE))
    else $error("channel one down outside allowed modes");
  AST_HOLD: assert property ((!run5[0] && !ld[0] && !standby) |=>
    $stable(cnt_r[0]))
    else $error("halted counter moved");
  AST_STBY: assert property (standby |=> (cnt_r[3] == CNT_RST &&
    gr_r[5] == GR_RST && run_r == RUN_RST && sync_r == SYN_RST))
    else $error("standby did not initialise");
  AST_RSV: assert property (run_r[5:3] == 3'h0 && sync_r[5:3] == 3'h0)
    else $error("reserved bits set");
  AST_OVF: assert property ((ovf_ev[0] && !standby) |=>
    ovf_r[0] && cnt_r[0] == CNT_RST)
    else $error("overflow not flagged");
  // Only channels one and two keep an underflow flag
  AST_UNF: assert property ((unf_ev[1] && !standby) |=>
    unf_r[1] && cnt_r[1] == CNT_MAX)
    else $error("underflow not flagged");
  AST_DIR: assert property ((dn_ev[1] && !standby) |=> !stat_w[ST_DIR])
    else $error("direction not reported as down");
  AST_SYNC_LD: assert property ((sync_ld && sync5[4] && !standby) |=>
    cnt_r[4] == $past(wr_data))
    else $error("synchronous preset missed");
  // Follower clears in the same cycle as the channel that clears itself
  AST_SYNC_CLR: assert property ((clr_own[0] && sync5[0] && sync5[3] && run5[3] &&
    csrc[3] == MTC_CLR_SYNC && !ld[3] && !standby) |=> cnt_r[3] == CNT_RST)
    else $error("synchronous clear missed");
  AST_PIN_INIT: assert property ((wr_ctl_c[1] && !run5[1] && !standby) |=>
    pin_out_r[1] == $past(wr_data[CF_INIT]))
    else $error("pin not set to initial level");
  AST_PIN_HOLD: assert property ((!run5[0] && !wr_ctl_c[0] && !standby) |=>
    $stable(pin_out_r[0]))
    else $error("halted pin level changed");
  AST_PIN_OE: assert property ((!ctl_r[2][CF_CAP] && !standby) |=> pin_oe_r[2])
    else $error("compare pin not driven");
  AST_RUN_WR: assert property ((wr_run && !standby) |=>
    run_r == ($past(wr_data[7:0]) & RSV_MSK))
    else $error("run bits not taken");
  AST_CAP: assert property ((cap_ev[3] && !wr_gr && !standby) |=>
    gr_r[GR_BASE[3]] == $past(cnt_r[3]))
    else $error("capture value missed");
  AST_BUF: assert property ((!ctl_r[0][CF_CAP] && ctl_r[0][CF_BUF] && match[0] &&
    run5[0] && !wr_gr && !standby) |=> gr_r[0] == $past(gr_r[2]))
    else $error("buffer transfer missed");

  COV_OVF: cover property (ovf_ev[0]);
  COV_SYNC: cover property (sync_ld && sync5[1]);
  COV_CAP: cover property (cap_ev[3]);
  COV_SYNC_CLR: cover property (clr_own[0] && |(clr & sync5 & ~clr_own));
  COV_UNF: cover property (unf_ev[1]);

endmodule // mtc_core
`default_nettype wire

// ===== verif/mtc_core_tb.sv
// Self-checking bench of the five-channel timer core
`timescale 1ns/100ps
`default_nettype none
module mtc_core_tb
  import mtc_pkg::*;
();
  logic            clk;
  logic            sys_rst;
  logic            standby;
  logic [5:0]      addr;
  logic [15:0]     wr_data;
  logic            wr_en;
  logic            rd_en;
  wire logic [15:0] rd_data_r;
  logic [NCH-1:0]  phase_up;
  logic [NCH-1:0]  phase_dn;
  logic [NCH-1:0]  pin_in;
  wire logic [NCH-1:0] pin_out_r;
  wire logic [NCH-1:0] pin_oe_r;
  int              num_errors = 0;
  int              num_checks = 0;
  int              cycles     = 0;
  logic [16:0]     exp_q [$];
  logic [16:0]     e;
  logic            rd_pend    = 1'b0;
  logic [15:0]     rng        = 16'h6783;
  logic [15:0]     v;
  logic [15:0]     d;

  mtc_core mtc_core_inst (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .standby   (standby),
    .addr      (addr),
    .wr_data   (wr_data),
    .wr_en     (wr_en),
    .rd_en     (rd_en),
    .rd_data_r (rd_data_r),
    .phase_up  (phase_up),
    .phase_dn  (phase_dn),
    .pin_in    (pin_in),
    .pin_out_r (pin_out_r),
    .pin_oe_r  (pin_oe_r)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  function automatic logic [15:0] nxt_rand();
    rng = rng ^ (rng << 7);
    rng = rng ^ (rng >> 9);
    rng = rng ^ (rng << 8);
    return rng;
  endfunction

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ***********************************
  // Register port master
  // ***********************************
  task automatic wr(input logic [5:0] a, input logic [15:0] dat);
    @(posedge clk);
    addr    <= a;
    wr_data <= dat;
    wr_en   <= 1'b1;
    @(posedge clk);
    wr_en   <= 1'b0;
  endtask

  // Skip set: value is taken by rdv, not compared by the monitor
  task automatic rd(input logic [5:0] a, input logic [15:0] ex, input logic skip = 1'b0);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    exp_q.push_back({skip, ex});
    @(posedge clk);
    rd_en <= 1'b0;
  endtask

  task automatic rdv(input logic [5:0] a, output logic [15:0] val);
    rd(a, 16'h0000, 1'b1);
    #1 val = rd_data_r;
  endtask

  // Read data stands only one cycle after the strobe
  always @(posedge clk) begin
    if (rd_pend && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      if (!e[16]) check("rd_data_r", rd_data_r, e[15:0]);
    end
    rd_pend <= rd_en;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      num_errors++;
      $display("timeout after %0d cycles", cycles);
      complete_run();
    end
  end

  task automatic reset_vals();
    for (int a = 0; a < 5; a++) rd(a[5:0], CNT_RST);
    for (int a = 8; a < 24; a++) rd(a[5:0], GR_RST);
    for (int a = 32; a < 37; a++) rd(a[5:0], CTL_RST);
    rd(A_RUN, {8'h00, RUN_RST});
    rd(A_SYNC, {8'h00, SYN_RST});
    rd(A_STAT, 16'h0F00);
  endtask

  // ***********************************
  // Main sequence
  // ***********************************
  initial begin
    sys_rst  = 1'b1;
    standby  = 1'b0;
    wr_en    = 1'b0;
    rd_en    = 1'b0;
    addr     = 6'h00;
    wr_data  = 16'h0000;
    phase_up = 5'h00;
    phase_dn = 5'h00;
    pin_in   = 5'h00;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    reset_vals();
    $display("reset values done");
    // Random data, pin inputs fed too since all channels stay in compare mode
    for (int a = 8; a < 24; a++) begin
      d = nxt_rand();
      pin_in <= d[4:0];
      wr(a[5:0], d);
      rd(a[5:0], d);
    end
    wr(A_RUN, 16'h00FF);
    rd(A_RUN, {8'h00, RSV_MSK});
    wr(A_RUN, 16'h0000);
    wr(A_SYNC, 16'h00FF);
    rd(A_SYNC, {8'h00, RSV_MSK});
    wr(6'h3F, 16'hFFFF);
    rd(6'h3F, 16'h0000);
    $display("register access done");
    // Channels zero, three and four locked, one stays independent
    wr(A_SYNC, 16'h00C1);
    rdv(6'h01, v);
    d = nxt_rand();
    wr(6'h03, d);
    rd(6'h00, d);
    rd(6'h03, d);
    rd(6'h04, d);
    rd(6'h01, v);
    wr(A_SYNC, 16'h0000);
    $display("synchronous preset done");
    // Phase mode on channel one, both pulses together do not count
    wr(6'h21, 16'h0001);
    wr(6'h01, 16'h0000);
    wr(A_STAT, 16'h0000);
    wr(A_RUN, 16'h0002);
    repeat (3) begin
      @(posedge clk);
      phase_dn <= 5'h02;
      @(posedge clk);
      phase_dn <= 5'h00;
    end
    @(posedge clk);
    phase_up <= 5'h02;
    phase_dn <= 5'h02;
    @(posedge clk);
    phase_up <= 5'h00;
    phase_dn <= 5'h00;
    wr(A_RUN, 16'h0000);
    rd(6'h01, 16'hFFFD);
    rd(A_STAT, 16'h0E20);
    wr(6'h21, 16'h0000);
    $display("phase counting done");
    // Wrap from all ones; about 42 running cycles give 10 or 11 ticks
    wr(6'h00, 16'hFFFF);
    wr(A_STAT, 16'h0000);
    wr(A_RUN, 16'h0001);
    repeat (40) @(posedge clk);
    wr(A_RUN, 16'h0000);
    rdv(6'h00, v);
    check("count_range", {15'h0000, (v >= 16'h0009 && v <= 16'h000A)}, 16'h0001);
    repeat (20) @(posedge clk);
    rd(6'h00, v);
    rdv(A_STAT, d);
    check("overflow_flag", {15'h0000, d[0]}, 16'h0001);
    $display("counting done");
    // Halted channel: control write moves the pin to its initial level
    wr(6'h20, 16'h0040);
    @(posedge clk);
    #1 check("pin_out_r", {15'h0000, pin_out_r[0]}, 16'h0001);
    check("pin_oe_r", {15'h0000, pin_oe_r[0]}, 16'h0001);
    wr(6'h20, 16'h0000);
    @(posedge clk);
    #1 check("pin_out_r", {15'h0000, pin_out_r[0]}, 16'h0000);
    $display("pin level done");
    // Channel three follows the own compare clear of channel zero at five
    wr(A_SYNC, 16'h0041);
    wr(6'h08, 16'h0005);
    wr(6'h20, 16'h0008);
    wr(6'h23, 16'h0010);
    wr(6'h00, 16'h0000);
    wr(A_RUN, 16'h0041);
    repeat (40) @(posedge clk);
    wr(A_RUN, 16'h0000);
    rdv(6'h00, v);
    check("clear_range", {15'h0000, (v >= 16'h0004 && v <= 16'h0005)}, 16'h0001);
    rd(6'h03, v);
    wr(6'h20, 16'h0000);
    wr(6'h23, 16'h0000);
    wr(A_SYNC, 16'h0000);
    $display("synchronous clear done");
    // Standby must undo everything set beforehand
    wr(6'h02, nxt_rand());
    wr(A_SYNC, 16'h0041);
    wr(A_RUN, 16'h0041);
    @(posedge clk);
    standby <= 1'b1;
    @(posedge clk);
    standby <= 1'b0;
    reset_vals();
    repeat (3) @(posedge clk);
    $display("standby done");
    complete_run();
  end
endmodule // mtc_core_tb
`default_nettype wire
